//--- common/sic_pkg.sv
// constants, field layout and helpers for the sensor interrupt controller
package sic_pkg;
	localparam int unsigned NUM_PROX = 3;
	localparam int unsigned SAMPLE_W = 16;
	// register port byte addresses
	localparam logic [7:0] ADDR_PIN_CFG = 8'h03;
	localparam logic [7:0] ADDR_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_MODE_FIRST = 8'h05;
	localparam logic [7:0] ADDR_MODE_SECOND = 8'h06;
	localparam logic [7:0] ADDR_PENDING = 8'h21;
	// reset value and implemented flag mask
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] IMPL_FLAGS = 8'h3F;
	// pin configuration bits
	localparam int unsigned CFG_OE_BIT = 0;
	localparam int unsigned CFG_MODE_BIT = 1;
	// flag and enable positions
	localparam int unsigned BIT_LIGHT_LO = 0;
	localparam int unsigned BIT_LIGHT_HI = 1;
	localparam int unsigned BIT_PROX_BASE = 2;
	localparam int unsigned BIT_CMD = 5;
	// mode field positions
	localparam int unsigned PROX_ONE_MODE_LSB = 4;
	localparam int unsigned PROX_TWO_MODE_LSB = 6;
	localparam int unsigned PROX_THREE_MODE_LSB = 0;
	localparam int unsigned CMD_MODE_BIT = 2;
	localparam int unsigned LIGHT_EXIT_BIT = 0;
	localparam int unsigned LIGHT_IR_BIT = 1;
	localparam int unsigned LIGHT_ENTER_BIT = 2;
	// proximity and light mode encodings, current-sample history bit
	localparam logic [1:0] PROX_EVERY = 2'h0;
	localparam logic [1:0] PROX_CROSS = 2'h1;
	localparam logic [1:0] PROX_ABOVE = 2'h3;
	localparam logic [2:0] LIGHT_EVERY = 3'h0;
	localparam logic [7:0] HIST_CURRENT = 8'h01;

	// compressed 8-bit code: upper nibble exponent, lower nibble mantissa
	function automatic logic [SAMPLE_W:0] sic_decode(input logic [7:0] code);
		logic [35:0] wide;
		wide = 36'h0;
		if (code != 8'h00) begin
			wide = ({31'h0, 1'b1, code[3:0]} << code[7:4]) >> 4;
		end
		if (wide[35:SAMPLE_W] != '0) begin
			sic_decode = {1'b0, {SAMPLE_W{1'b1}}};
		end else begin
			sic_decode = {1'b0, wide[SAMPLE_W-1:0]};
		end
	endfunction : sic_decode
endpackage : sic_pkg

//--- common/sic_chan_if.sv
// per-channel link between the controller and a proximity evaluator
interface sic_chan_if;
	logic sample_valid;
	logic [15:0] sample;
	logic [7:0] threshold;
	logic [7:0] hyst;
	logic [7:0] history;
	logic enable;
	logic [1:0] mode;
	logic set;
	modport ctrl (
		output sample_valid, sample, threshold, hyst, history, enable, mode,
		input set
	);
	modport eval (
		input sample_valid, sample, threshold, hyst, history, enable, mode,
		output set
	);
endinterface : sic_chan_if

//--- design/sic_prox_eval.sv
// proximity threshold evaluation with hysteresis and history check
module sic_prox_eval (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic clock_en_in,
	sic_chan_if.eval ch
);
	logic [7:0] hist_q;
	logic [7:0] hist_d;
	logic state_q;
	logic state_d;
	logic [16:0] th;
	logic [16:0] hy;
	logic above;
	logic below;
	logic cond;
	logic [7:0] mask;
	logic [7:0] seen;

	always_comb begin
		th = sic_pkg::sic_decode(ch.threshold);
		hy = sic_pkg::sic_decode(ch.hyst);
		// hysteresis band around the threshold; inside the band the old state holds
		above = {1'b0, ch.sample} > (th + hy); // RL11
		below = ({1'b0, ch.sample} + hy) < th; // RL11
		cond = above ? 1'b1 : (below ? 1'b0 : state_q);
		mask = ch.history | sic_pkg::HIST_CURRENT;
		hist_d = hist_q;
		state_d = state_q;
		seen = {hist_q[6:0], cond} & mask;
		if (ch.sample_valid) begin
			hist_d = {hist_q[6:0], cond};
			// state changes only when every checked sample agrees
			if (seen == mask) begin // RL11
				state_d = 1'b1;
			end else if (seen == 8'h00) begin
				state_d = 1'b0;
			end
		end
		ch.set = 1'b0;
		if (ch.sample_valid && ch.enable) begin
			case (ch.mode)
				sic_pkg::PROX_EVERY: ch.set = 1'b1; // RL8
				sic_pkg::PROX_CROSS: ch.set = state_d != state_q; // RL9
				sic_pkg::PROX_ABOVE: ch.set = state_d; // RL10
				default: ch.set = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			hist_q <= sic_pkg::RST_REG;
			state_q <= 1'b0;
		end else if (clock_en_in) begin
			hist_q <= hist_d;
			state_q <= state_d;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	every_sample_a: assert property ( // RL8
		(ch.sample_valid && ch.enable && ch.mode == 2'h0) |-> ch.set)
		else $error("per-sample mode did not set the flag");
	cross_set_a: assert property ( // RL9
		(clock_en_in && ch.sample_valid && ch.enable && ch.mode == 2'h1 && ch.set)
		|=> (state_q != $past(state_q)))
		else $error("crossing flag without a state change");
	above_set_a: assert property ( // RL10
		(ch.sample_valid && ch.enable && ch.mode == 2'h3 && ch.set) |-> state_d)
		else $error("above flag set while not above threshold");
	history_hold_a: assert property ( // RL11
		(clock_en_in && ch.sample_valid && seen != mask && seen != 8'h00)
		|=> (state_q == $past(state_q)))
		else $error("state moved without a consistent history");
endmodule : sic_prox_eval

//--- design/sic_irq_ctrl.sv
// sensor interrupt controller: registers, pending flags and interrupt pin
// Operation
// RL1: interrupt pin driven only while the pin output-enable bit is set.
// RL2: pin asserts when any bit of enable AND pending flags is one.
// RL3: with deassert mode zero, flags stay set until the host clears them.
// RL4: host write to pending flags clears bits written one, keeps zeros.
// RL5: host reads flags, keeps a copy, writes it back to clear them.
// RL6: host normally leaves deassert mode zero, writing one to pin config.
// RL7: sequencer sets flags from enable and both mode registers per channel.
// RL8: proximity mode 00 sets the flag after every completed sample.
// RL9: proximity mode 01 sets the flag whenever the threshold is crossed.
// RL10: proximity mode 11 sets the flag while the sample is above threshold.
// RL11: proximity evaluation applies compressed hysteresis and a history check.
// RL12: command mode 0 sets the command flag on every new response value.
// RL13: light flags bits 1:0, proximity bits 2,3,4; modes at fixed fields.
// RL14: a set in the same cycle as a host clear keeps the flag set.
module sic_irq_ctrl (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic clock_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [2:0] prox_sample_valid_in,
	input wire logic [2:0][15:0] prox_sample_in,
	input wire logic [2:0][7:0] prox_threshold_in,
	input wire logic [7:0] prox_hysteresis_in,
	input wire logic [7:0] prox_history_check_in,
	input wire logic light_vis_sample_in,
	input wire logic light_vis_exit_in,
	input wire logic light_vis_enter_in,
	input wire logic light_ir_exit_in,
	input wire logic light_ir_enter_in,
	input wire logic cmd_response_write_in,
	input wire logic [7:0] cmd_response_value_in,
	output logic int_pin_out,
	output logic int_pin_oe_n_out
);
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic [7:0] en_q;
	logic [7:0] en_d;
	logic [7:0] m1_q;
	logic [7:0] m1_d;
	logic [7:0] m2_q;
	logic [7:0] m2_d;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic int_q;
	logic int_d;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	wire logic [2:0] prox_set;
	logic stat_wr;
	logic stat_rd;
	logic [2:0] light_im;
	logic light_exit;
	logic light_enter;
	logic cmd_event;

	// one evaluator per proximity channel
	for (genvar i = 0; i < 3; i++) begin : g_prox
		localparam int unsigned MLSB = (i == 0) ? sic_pkg::PROX_ONE_MODE_LSB :
			((i == 1) ? sic_pkg::PROX_TWO_MODE_LSB : sic_pkg::PROX_THREE_MODE_LSB);
		sic_chan_if chan ();
		assign chan.sample_valid = prox_sample_valid_in[i];
		assign chan.sample = prox_sample_in[i];
		assign chan.threshold = prox_threshold_in[i];
		assign chan.hyst = prox_hysteresis_in;
		assign chan.history = prox_history_check_in;
		assign chan.enable = en_q[sic_pkg::BIT_PROX_BASE + i]; // RL13
		assign chan.mode = (i == 2) ? m2_q[MLSB +: 2] : m1_q[MLSB +: 2]; // RL7
		assign prox_set[i] = chan.set;
		sic_prox_eval u_eval (
			.clock_in(clock_in),
			.sys_rst_in(sys_rst_in),
			.clock_en_in(clock_en_in),
			.ch(chan.eval)
		);
	end

	always_comb begin
		stat_wr = reg_wr_in && (reg_addr_in == sic_pkg::ADDR_PENDING);
		stat_rd = reg_rd_in && (reg_addr_in == sic_pkg::ADDR_PENDING);
		light_im = m1_q[2:0];
		// ir channel is picked by the mode's middle bit; no per-sample ir events
		light_exit = light_im[sic_pkg::LIGHT_IR_BIT] ? light_ir_exit_in : light_vis_exit_in;
		light_enter = light_im[sic_pkg::LIGHT_IR_BIT] ? light_ir_enter_in : light_vis_enter_in;
		// command mode 1 reacts only to error codes (top bit of the response)
		cmd_event = cmd_response_write_in &&
			(!m2_q[sic_pkg::CMD_MODE_BIT] || cmd_response_value_in[7]); // RL12
		set_vec = 8'h00;
		set_vec[sic_pkg::BIT_PROX_BASE +: 3] = prox_set; // RL13
		set_vec[sic_pkg::BIT_LIGHT_LO] = en_q[sic_pkg::BIT_LIGHT_LO] && // RL7
			((light_im == sic_pkg::LIGHT_EVERY && light_vis_sample_in) ||
			(light_im[sic_pkg::LIGHT_EXIT_BIT] && light_exit));
		set_vec[sic_pkg::BIT_LIGHT_HI] = en_q[sic_pkg::BIT_LIGHT_HI] &&
			light_im[sic_pkg::LIGHT_ENTER_BIT] && light_enter; // RL7
		set_vec[sic_pkg::BIT_CMD] = en_q[sic_pkg::BIT_CMD] && cmd_event; // RL12
		clr_vec = 8'h00;
		if (stat_wr) begin
			clr_vec = reg_wdata_in; // RL4
		end
		// deassert mode one: a host read of the flags clears what it returned
		if (stat_rd && cfg_q[sic_pkg::CFG_MODE_BIT]) begin
			clr_vec = clr_vec | flags_q;
		end
		// set is applied after clear so a coincident event survives
		flags_d = ((flags_q & ~clr_vec) | set_vec) & sic_pkg::IMPL_FLAGS; // RL3 RL4 RL14
		cfg_d = cfg_q;
		en_d = en_q;
		m1_d = m1_q;
		m2_d = m2_q;
		if (reg_wr_in) begin
			if (reg_addr_in == sic_pkg::ADDR_PIN_CFG) begin
				cfg_d = reg_wdata_in & 8'h03;
			end else if (reg_addr_in == sic_pkg::ADDR_ENABLE) begin
				en_d = reg_wdata_in & sic_pkg::IMPL_FLAGS;
			end else if (reg_addr_in == sic_pkg::ADDR_MODE_FIRST) begin
				m1_d = reg_wdata_in;
			end else if (reg_addr_in == sic_pkg::ADDR_MODE_SECOND) begin
				m2_d = reg_wdata_in & 8'h0F;
			end
		end
		rdata_d = rdata_q;
		if (reg_rd_in) begin
			if (reg_addr_in == sic_pkg::ADDR_PIN_CFG) begin
				rdata_d = cfg_q;
			end else if (reg_addr_in == sic_pkg::ADDR_ENABLE) begin
				rdata_d = en_q;
			end else if (reg_addr_in == sic_pkg::ADDR_MODE_FIRST) begin
				rdata_d = m1_q;
			end else if (reg_addr_in == sic_pkg::ADDR_MODE_SECOND) begin
				rdata_d = m2_q;
			end else if (reg_addr_in == sic_pkg::ADDR_PENDING) begin
				rdata_d = flags_q;
			end else begin
				rdata_d = 8'h00;
			end
		end
		// pin registered to keep glitches off the open-drain line, one cycle late
		int_d = cfg_q[sic_pkg::CFG_OE_BIT] && ((en_q & flags_q) != 8'h00); // RL1 RL2
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cfg_q <= sic_pkg::RST_REG;
			en_q <= sic_pkg::RST_REG;
			m1_q <= sic_pkg::RST_REG;
			m2_q <= sic_pkg::RST_REG;
			flags_q <= sic_pkg::RST_REG;
			rdata_q <= sic_pkg::RST_REG;
			int_q <= 1'b0;
		end else if (clock_en_in) begin
			cfg_q <= cfg_d;
			en_q <= en_d;
			m1_q <= m1_d;
			m2_q <= m2_d;
			flags_q <= flags_d;
			rdata_q <= rdata_d;
			int_q <= int_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	// open-drain: output is always low, the enable decides whether it pulls
	assign int_pin_out = 1'b0;
	assign int_pin_oe_n_out = ~int_q;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_host_clear;
		clock_en_in && stat_wr && set_vec == 8'h00 && !(stat_rd && cfg_q[1]);
	endsequence
	sequence s_clear_result;
		flags_q == ($past(flags_q) & ~$past(reg_wdata_in) & 8'h3F);
	endsequence

	pin_gate_a: assert property ( // RL1
		(!$past(cfg_q[0]) && $past(clock_en_in)) |-> int_pin_oe_n_out)
		else $error("interrupt pin driven while its output is disabled");
	pin_and_a: assert property ( // RL2
		(clock_en_in && cfg_q[0] && (en_q & flags_q) != 8'h00) |=> !int_pin_oe_n_out)
		else $error("interrupt pin not asserted for an enabled pending flag");
	flag_hold_a: assert property ( // RL3
		(!cfg_q[1] && !stat_wr) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
		else $error("pending flag dropped without a host clear");
	write_clear_a: assert property ( // RL4
		s_host_clear |=> s_clear_result)
		else $error("write-one-to-clear gave the wrong flags");
	light_sample_a: assert property ( // RL7
		(clock_en_in && en_q[0] && m1_q[2:0] == 3'h0 && light_vis_sample_in) |=> flags_q[0])
		else $error("light per-sample flag not set");
	prox_one_a: assert property ( // RL13
		(clock_en_in && prox_set[0]) |=> flags_q[2])
		else $error("first proximity event not on flag bit 2");
	cmd_flag_a: assert property ( // RL12
		(clock_en_in && en_q[5] && !m2_q[2] && cmd_response_write_in) |=> flags_q[5])
		else $error("command flag not set on new response");
	set_wins_a: assert property ( // RL14
		(clock_en_in && stat_wr && set_vec != 8'h00)
		|=> ((flags_q & $past(set_vec)) == $past(set_vec)))
		else $error("event lost against a coincident clear");

	// a low clock enable must freeze every register, the pin included
	pin_freeze_a: assert property ( // RL1
		!clock_en_in |=> $stable(int_pin_oe_n_out))
		else $error("interrupt pin moved while the clock enable was low");
	flags_freeze_a: assert property ( // RL3
		!clock_en_in |=> $stable(flags_q))
		else $error("pending flags moved while the clock enable was low");
	setup_freeze_a: assert property ( // RL7
		!clock_en_in |=> ($stable(cfg_q) && $stable(en_q)
		&& $stable(m1_q) && $stable(m2_q)))
		else $error("setup registers moved while the clock enable was low");
	rdata_freeze_a: assert property ( // RL13
		(!clock_en_in || !reg_rd_in) |=> $stable(reg_rdata_out))
		else $error("read data changed without a taken read");

	// reserved bits read as zero, so software may write whole bytes
	cfg_reserved_a: assert property ( // RL1
		cfg_q[7:2] == 6'h00)
		else $error("reserved pin configuration bits are set");
	flag_reserved_a: assert property ( // RL13
		en_q[7:6] == 2'h0 && flags_q[7:6] == 2'h0 && m2_q[7:4] == 4'h0)
		else $error("reserved enable, flag or mode bits are set");

	cfg_write_a: assert property ( // RL1
		(clock_en_in && reg_wr_in && reg_addr_in == sic_pkg::ADDR_PIN_CFG)
		|=> cfg_q == ($past(reg_wdata_in) & 8'h03))
		else $error("pin configuration write not taken");
	enable_write_a: assert property ( // RL2
		(clock_en_in && reg_wr_in && reg_addr_in == sic_pkg::ADDR_ENABLE)
		|=> en_q == ($past(reg_wdata_in) & sic_pkg::IMPL_FLAGS))
		else $error("interrupt enable write not taken");
	mode_write_a: assert property ( // RL7
		(clock_en_in && reg_wr_in && reg_addr_in == sic_pkg::ADDR_MODE_FIRST)
		|=> m1_q == $past(reg_wdata_in))
		else $error("first mode register write not taken");
	mode_two_write_a: assert property ( // RL7
		(clock_en_in && reg_wr_in && reg_addr_in == sic_pkg::ADDR_MODE_SECOND)
		|=> m2_q == ($past(reg_wdata_in) & 8'h0F))
		else $error("second mode register write not taken");
	flags_read_a: assert property ( // RL3
		(clock_en_in && stat_rd) |=> reg_rdata_out == $past(flags_q))
		else $error("flag read returned the wrong value");
	unmapped_read_a: assert property ( // RL13
		(clock_en_in && reg_rd_in && reg_addr_in > sic_pkg::ADDR_MODE_SECOND && !stat_rd)
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped address did not read as zero");

	// a flag may only rise from an enabled event of the cycle before
	set_needs_enable_a: assert property ( // RL7
		clock_en_in |=> (flags_q & ~$past(flags_q) & ~$past(en_q)) == 8'h00)
		else $error("flag rose while its enable was clear");
	set_needs_event_a: assert property ( // RL7
		clock_en_in |=> (flags_q & ~$past(flags_q) & ~$past(set_vec)) == 8'h00)
		else $error("flag rose without an event");
	read_clear_a: assert property ( // RL3
		(clock_en_in && stat_rd && cfg_q[1] && !stat_wr)
		|=> (flags_q & ~$past(set_vec)) == 8'h00)
		else $error("flag read in deassert mode one left flags set");
	light_exit_a: assert property ( // RL7
		(clock_en_in && en_q[0] && m1_q[0] && light_exit) |=> flags_q[0])
		else $error("light exit event did not set flag 0");
	light_enter_a: assert property ( // RL7
		(clock_en_in && en_q[1] && m1_q[2] && light_enter) |=> flags_q[1])
		else $error("light enter event did not set flag 1");
	cmd_error_a: assert property ( // RL12
		(clock_en_in && en_q[5] && m2_q[2] && cmd_response_write_in
		&& cmd_response_value_in[7]) |=> flags_q[5])
		else $error("command flag not set on a new error code");
	cmd_quiet_a: assert property ( // RL12
		(clock_en_in && m2_q[2] && !cmd_response_value_in[7] && !flags_q[5]) |=> !flags_q[5])
		else $error("command flag set by a response without an error code");
	prox_two_a: assert property ( // RL13
		(clock_en_in && prox_set[1]) |=> flags_q[3])
		else $error("second proximity event not on flag bit 3");
	prox_three_a: assert property ( // RL13
		(clock_en_in && prox_set[2]) |=> flags_q[4])
		else $error("third proximity event not on flag bit 4");
	prox_gate_a: assert property ( // RL7
		(!en_q[2] && !en_q[3] && !en_q[4]) |-> prox_set == 3'h0)
		else $error("disabled proximity channel raised an event");
	prox_invalid_a: assert property ( // RL7
		(m1_q[5:4] == 2'h2) |-> !prox_set[0])
		else $error("reserved proximity mode raised an event");
	pin_idle_a: assert property ( // RL2
		(clock_en_in && (en_q & flags_q) == 8'h00) |=> int_pin_oe_n_out)
		else $error("interrupt pin pulled with no enabled pending flag");
	pin_drop_a: assert property ( // RL1
		(clock_en_in && !cfg_q[0]) |=> int_pin_oe_n_out)
		else $error("interrupt pin pulled after its output was disabled");

	// event taken, pin setup still on one cycle later, then the pin pulls
	sequence s_prox_one_taken;
		clock_en_in && prox_set[0] && en_q[2];
	endsequence
	sequence s_pin_kept_on;
		clock_en_in && cfg_q[0] && en_q[2];
	endsequence
	event_to_pin_a: assert property ( // RL2
		s_prox_one_taken ##1 s_pin_kept_on |=> !int_pin_oe_n_out)
		else $error("proximity event did not reach the interrupt pin");
endmodule : sic_irq_ctrl

//--- verification/sic_host_model.sv
// host processor model that drives the register port
module sic_host_model (
	input wire logic clock_in,
	output logic [7:0] reg_addr_out,
	output logic reg_wr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_rd_out,
	input wire logic [7:0] reg_rdata_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] exp_q[$];
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		reg_rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock_in);
		#1;
		reg_addr_out = addr;
		reg_wdata_out = data;
		reg_wr_out = 1'b1;
		@(posedge clock_in);
		#1;
		reg_wr_out = 1'b0;
	endtask : wr
	// the expected byte is noted before the strobe is taken
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clock_in);
		#1;
		reg_addr_out = addr;
		reg_rd_out = 1'b1;
		exp_q.push_back(exp);
		@(posedge clock_in);
		#1;
		reg_rd_out = 1'b0;
	endtask : rd
	// clears only what was seen, so a later event on a flag that read as zero is never lost
	task automatic service(input logic [7:0] exp);
		logic [7:0] copy;
		rd(sic_pkg::ADDR_PENDING, exp);
		copy = reg_rdata_in;
		wr(sic_pkg::ADDR_PENDING, copy);
	endtask : service
endmodule : sic_host_model

//--- verification/sic_irq_ctrl_tb_top.sv
// self-checking bench for the sensor interrupt controller
module sic_irq_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] ADDRS [0:5] = '{sic_pkg::ADDR_PIN_CFG, sic_pkg::ADDR_ENABLE,
		sic_pkg::ADDR_MODE_FIRST, sic_pkg::ADDR_MODE_SECOND, sic_pkg::ADDR_PENDING, 8'h10};
	localparam logic [7:0] MASKS [0:3] = '{8'h03, 8'h3F, 8'hFF, 8'h0F};
	logic clock_in;
	logic sys_rst_in;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [8:0] ev_v;
	logic [15:0] smp;
	logic [7:0] cmd_val;
	logic pin;
	logic pin_oe_n;
	logic rd_seen;
	logic cfg_v;
	logic clk_en;
	logic [31:0] lfsr;
	int fails;
	int checks;
	sic_host_model host_u (.clock_in(clock_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
		.reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata));
	sic_irq_ctrl dut_u (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.clock_en_in(clk_en),
		.reg_addr_in(reg_addr),
		.reg_wr_in(reg_wr),
		.reg_wdata_in(reg_wdata),
		.reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata),
		.prox_sample_valid_in(ev_v[2:0]),
		.prox_sample_in({3{smp}}),
		.prox_threshold_in({3{8'h40}}),
		.prox_hysteresis_in(8'h00),
		.prox_history_check_in(8'h01),
		.light_vis_sample_in(ev_v[3]),
		.light_vis_exit_in(ev_v[4]),
		.light_vis_enter_in(ev_v[5]),
		.light_ir_exit_in(ev_v[6]),
		.light_ir_enter_in(ev_v[7]),
		.cmd_response_write_in(ev_v[8]),
		.cmd_response_value_in(cmd_val),
		.int_pin_out(pin),
		.int_pin_oe_n_out(pin_oe_n)
	);
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		lfsr_next = {v[30:0], ^(v & 32'h80200003)};
	endfunction : lfsr_next
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	// read data is registered, so it is compared one edge after the taken strobe
	always @(posedge clock_in) begin
		if (rd_seen === 1'b1) begin
			check("read data", reg_rdata, host_u.exp_q.pop_front());
		end
		rd_seen <= reg_rd;
	end
	task automatic pulse(input logic [8:0] vec, input logic [15:0] s);
		@(posedge clock_in);
		#1;
		ev_v = vec;
		smp = s;
		@(posedge clock_in);
		#1;
		ev_v = 9'h000;
	endtask : pulse
	// pin settles two edges after the event, then flags are read and all cleared
	task automatic ev(input logic [8:0] vec, input logic [15:0] s, input logic [7:0] exp);
		pulse(vec, s);
		@(posedge clock_in);
		#1;
		check("pin", {6'h00, pin, pin_oe_n}, {7'h00, !(cfg_v && exp != 8'h00)});
		host_u.rd(sic_pkg::ADDR_PENDING, exp);
		host_u.wr(sic_pkg::ADDR_PENDING, 8'hFF);
	endtask : ev
	task automatic modes(input logic [7:0] first, input logic [7:0] second);
		host_u.wr(sic_pkg::ADDR_MODE_FIRST, first);
		host_u.wr(sic_pkg::ADDR_MODE_SECOND, second);
	endtask : modes
	initial begin
		repeat (20000) @(posedge clock_in);
		fails++;
		finish_test();
	end
	initial begin
		ev_v = 9'h000;
		smp = 16'h0000;
		cmd_val = 8'h00;
		cfg_v = 1'b0;
		clk_en = 1'b1;
		rd_seen = 1'b0;
		lfsr = 32'hFA92A79A;
		fails = 0;
		checks = 0;
		sys_rst_in = 1'b1;
		repeat (4) @(posedge clock_in);
		#1;
		sys_rst_in = 1'b0;
		foreach (ADDRS[i]) host_u.rd(ADDRS[i], 8'h00);
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			host_u.wr(ADDRS[i], lfsr[7:0]);
			host_u.rd(ADDRS[i], lfsr[7:0] & MASKS[i]);
		end
		host_u.wr(sic_pkg::ADDR_PIN_CFG, 8'h01);
		cfg_v = 1'b1;
		host_u.wr(sic_pkg::ADDR_ENABLE, 8'h1C);
		modes(8'h00, 8'h00);
		lfsr = lfsr_next(lfsr);
		ev(9'h007, {12'h000, lfsr[3:0]}, 8'h1C);
		modes(8'h50, 8'h01);
		ev(9'h007, 16'h0100, 8'h1C);
		ev(9'h007, 16'h0100, 8'h00);
		ev(9'h007, 16'h0005, 8'h1C);
		modes(8'hF0, 8'h03);
		ev(9'h007, 16'h0005, 8'h00);
		ev(9'h007, 16'h0100, 8'h1C);
		ev(9'h007, 16'h0100, 8'h1C);
		modes(8'hA0, 8'h02);
		ev(9'h007, 16'h0100, 8'h00);
		modes(8'h00, 8'h00);
		pulse(9'h003, 16'h0000);
		host_u.wr(sic_pkg::ADDR_PENDING, 8'h04);
		repeat (5) @(posedge clock_in);
		host_u.rd(sic_pkg::ADDR_PENDING, 8'h08);
		fork
			host_u.wr(sic_pkg::ADDR_PENDING, 8'h04);
			ev(9'h001, 16'h0000, 8'h0C);
		join
		host_u.wr(sic_pkg::ADDR_PIN_CFG, 8'h00);
		cfg_v = 1'b0;
		ev(9'h001, 16'h0000, 8'h04);
		host_u.wr(sic_pkg::ADDR_PIN_CFG, 8'h01);
		cfg_v = 1'b1;
		host_u.wr(sic_pkg::ADDR_ENABLE, 8'h04);
		ev(9'h007, 16'h0000, 8'h04);
		host_u.wr(sic_pkg::ADDR_ENABLE, 8'h03);
		ev(9'h008, 16'h0000, 8'h01);
		modes(8'h04, 8'h00);
		ev(9'h020, 16'h0000, 8'h02);
		host_u.wr(sic_pkg::ADDR_ENABLE, 8'h20);
		cmd_val = 8'h01;
		ev(9'h100, 16'h0000, 8'h20);
		modes(8'h00, 8'h04);
		ev(9'h100, 16'h0000, 8'h00);
		cmd_val = 8'h81;
		pulse(9'h100, 16'h0000);
		host_u.service(8'h20);
		ev(9'h000, 16'h0000, 8'h00);
		host_u.wr(sic_pkg::ADDR_ENABLE, 8'h03);
		modes(8'h07, 8'h00);
		ev(9'h010, 16'h0000, 8'h00);
		ev(9'h0C0, 16'h0000, 8'h03);
		// an event while the clock enable is low must not be taken
		clk_en = 1'b0;
		pulse(9'h0C0, 16'h0000);
		clk_en = 1'b1;
		host_u.rd(sic_pkg::ADDR_PENDING, 8'h00);
		@(posedge clock_in);
		#1;
		sys_rst_in = 1'b1;
		@(posedge clock_in);
		#1;
		sys_rst_in = 1'b0;
		check("pin after reset", {7'h00, pin_oe_n}, 8'h01);
		host_u.rd(sic_pkg::ADDR_PIN_CFG, 8'h00);
		@(posedge clock_in);
		#1;
		finish_test();
	end
endmodule : sic_irq_ctrl_tb_top
